// file: design/sern_node.v
`timescale 1ns/100ps
`include "sern_defines.vh"

module sern_node #(
	parameter WIDTH     = 16,
	parameter ERR_DEPTH = 8,
	parameter PTR_W     = 3
) (
	// Clock and reset
	input  wire             sys_clk_i,
	input  wire             sys_rst_i,
	// Live condition pins, operation and questionable groups
	input  wire [WIDTH-1:0] oper_cond_i,
	input  wire [WIDTH-1:0] ques_cond_i,
	// Other summaries entering the summary byte
	input  wire             outq_sum_i,
	input  wire             std_event_sum_i,
	// Error push from device logic
	input  wire             err_push_i,
	input  wire [WIDTH-1:0] err_code_i,
	// Command port
	input  wire             cmd_valid_i,
	input  wire [2:0]       cmd_op_i,
	input  wire             cmd_grp_i,
	input  wire [1:0]       cmd_sel_i,
	input  wire [WIDTH-1:0] cmd_wdata_i,
	output reg              rsp_valid_o,
	output reg  [WIDTH-1:0] rsp_data_o,
	// Summaries
	output reg              oper_sum_o,
	output reg              ques_sum_o,
	output reg  [7:0]       summary_byte_o
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	reg [WIDTH-1:0] cond_s1_q [0:1];
	reg [WIDTH-1:0] cond_q    [0:1];
	reg [WIDTH-1:0] cond_d1_q [0:1];
	reg [WIDTH-1:0] event_q   [0:1];
	reg [WIDTH-1:0] mask_q    [0:1];
	reg [WIDTH-1:0] fall_q    [0:1];
	reg [WIDTH-1:0] rise_q    [0:1];
	reg [WIDTH-1:0] err_mem   [0:ERR_DEPTH-1];
	reg [PTR_W:0]   err_cnt_q;
	reg             outq_s1_q;
	reg             outq_q;
	reg             esb_s1_q;
	reg             esb_q;

	// Command decode shared by the register and stack processes
	wire             do_cmd  = cmd_valid_i;
	wire             is_pre  = do_cmd && (cmd_op_i == `SERN_CMD_PRESET);
	wire             err_pop = do_cmd && (cmd_op_i == `SERN_CMD_RD_ERROR);
	wire             err_any = (err_cnt_q != {(PTR_W+1){1'b0}});
	// Slot of the newest entry; wraps to the top slot when full
	wire [PTR_W-1:0] top_idx = err_cnt_q[PTR_W-1:0] -
		{{(PTR_W-1){1'b0}}, 1'b1};

	// Summary of one group: any enabled latched event
	function summ;
		input [WIDTH-1:0] ev;
		input [WIDTH-1:0] en;
		begin
			summ = |(ev & en);
		end
	endfunction

	// Push taken only with room and no pop in the same cycle; a code
	// pushed into a full stack is lost, with no overflow flag to show it
	function push_ok;
		input           push;
		input           pop;
		input [PTR_W:0] cnt;
		begin
			push_ok = push && !pop && (cnt != ERR_DEPTH[PTR_W:0]);
		end
	endfunction

	wire             err_take = push_ok(err_push_i, err_pop, err_cnt_q);

	// ------------------------------------------------------------------
	// Condition sync, edge filters, event latch, filter and mask regs
	// ------------------------------------------------------------------
	integer g;
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (g = 0; g < 2; g = g + 1) begin
				cond_s1_q[g] <= {WIDTH{1'b0}};
				cond_q[g]    <= {WIDTH{1'b0}};
				cond_d1_q[g] <= {WIDTH{1'b0}};
				event_q[g]   <= {WIDTH{1'b0}};
				mask_q[g]    <= `SERN_MASK_PRESET;
				fall_q[g]    <= `SERN_FALL_PRESET;
				rise_q[g]    <= `SERN_RISE_PRESET;
			end
		end else begin
			// Pins come from outside, two stages before use
			// Edge detect compares the synced value with its delayed copy
			cond_s1_q[0] <= oper_cond_i;
			cond_s1_q[1] <= ques_cond_i;
			for (g = 0; g < 2; g = g + 1) begin
				cond_q[g]    <= cond_s1_q[g];
				cond_d1_q[g] <= cond_q[g];
				// New edges win over a read clear in the same cycle
				event_q[g] <= ((do_cmd && cmd_op_i == `SERN_CMD_RD_EVENT &&
					cmd_grp_i == g[0]) ? {WIDTH{1'b0}} : event_q[g])
					| (cond_q[g] & ~cond_d1_q[g] & rise_q[g])
					| (~cond_q[g] & cond_d1_q[g] & fall_q[g]);
				if (is_pre) begin
					rise_q[g] <= `SERN_RISE_PRESET;
					fall_q[g] <= `SERN_FALL_PRESET;
					mask_q[g] <= `SERN_MASK_PRESET;
				end else if (do_cmd && cmd_grp_i == g[0]) begin
					// Full 16-bit hold of written values
					if (cmd_op_i == `SERN_CMD_WR_MASK)
						mask_q[g] <= cmd_wdata_i;
					if (cmd_op_i == `SERN_CMD_WR_FALL)
						fall_q[g] <= cmd_wdata_i;
					if (cmd_op_i == `SERN_CMD_WR_RISE)
						rise_q[g] <= cmd_wdata_i;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Error stack: newest first, signed codes stored as given
	// ------------------------------------------------------------------
	always @(posedge sys_clk_i) begin
		// Push into the slot a same-cycle pop would free is avoided
		// No reset: a slot is never read before it has been pushed
		if (err_take)
			err_mem[err_cnt_q[PTR_W-1:0]] <= err_code_i;
	end

	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			err_cnt_q <= {(PTR_W+1){1'b0}};
		end else if (err_pop && err_any) begin
			err_cnt_q <= err_cnt_q - {{PTR_W{1'b0}},1'b1};
		end else if (err_take) begin
			err_cnt_q <= err_cnt_q + {{PTR_W{1'b0}},1'b1};
		end
	end

	// ------------------------------------------------------------------
	// Responses, one cycle after the command
	// ------------------------------------------------------------------
	// Registered so the answer never rides on same-cycle command lines
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= {WIDTH{1'b0}};
		end else begin
			rsp_valid_o <= do_cmd;
			case (cmd_op_i)
			`SERN_CMD_RD_COND:  rsp_data_o <= cond_q[cmd_grp_i];
			`SERN_CMD_RD_EVENT: rsp_data_o <= event_q[cmd_grp_i];
			`SERN_CMD_RD_ERROR: rsp_data_o <= err_any ?
				err_mem[top_idx] : `SERN_NO_ERROR;
			`SERN_CMD_RD_PARTS: begin
				case (cmd_sel_i)
				`SERN_SEL_MASK: rsp_data_o <= mask_q[cmd_grp_i];
				`SERN_SEL_FALL: rsp_data_o <= fall_q[cmd_grp_i];
				`SERN_SEL_RISE: rsp_data_o <= rise_q[cmd_grp_i];
				default:        rsp_data_o <= {WIDTH{1'b0}};
				endcase
			end
			default: rsp_data_o <= {WIDTH{1'b0}};
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Summaries and summary byte, registered from event, mask, error count and synced summary inputs
	// ------------------------------------------------------------------
	// A summary stays high while any enabled event remains latched
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			oper_sum_o     <= 1'b0;
			ques_sum_o     <= 1'b0;
			summary_byte_o <= 8'h00;
			outq_s1_q      <= 1'b0;
			outq_q         <= 1'b0;
			esb_s1_q       <= 1'b0;
			esb_q          <= 1'b0;
		end else begin
			outq_s1_q  <= outq_sum_i;
			outq_q     <= outq_s1_q;
			esb_s1_q   <= std_event_sum_i;
			esb_q      <= esb_s1_q;
			// A new enabled event raises the summary next cycle
			oper_sum_o <= summ(event_q[0], mask_q[0]);
			ques_sum_o <= summ(event_q[1], mask_q[1]);
			summary_byte_o <= 8'h00;
			summary_byte_o[`SERN_SB_ERRQ] <= err_any;
			summary_byte_o[`SERN_SB_QUES] <= summ(event_q[1], mask_q[1]);
			summary_byte_o[`SERN_SB_OUTQ] <= outq_q;
			summary_byte_o[`SERN_SB_ESB]  <= esb_q;
			summary_byte_o[`SERN_SB_OPER] <= summ(event_q[0], mask_q[0]);
		end
	end

endmodule // sern_node

// file: design/sern_defines.vh
`ifndef SERN_DEFINES_VH
`define SERN_DEFINES_VH

// ----------------------------------------------------------------------
// Command codes on the register port
// ----------------------------------------------------------------------
`define SERN_CMD_RD_COND   3'h0
`define SERN_CMD_RD_EVENT  3'h1
`define SERN_CMD_WR_MASK   3'h2
`define SERN_CMD_WR_FALL   3'h3
`define SERN_CMD_WR_RISE   3'h4
`define SERN_CMD_PRESET    3'h5
`define SERN_CMD_RD_ERROR  3'h6
`define SERN_CMD_RD_PARTS  3'h7

// ----------------------------------------------------------------------
// Part select for reads of stored parts
// ----------------------------------------------------------------------
`define SERN_SEL_MASK      2'h0
`define SERN_SEL_FALL      2'h1
`define SERN_SEL_RISE      2'h2

// ----------------------------------------------------------------------
// Group indices
// ----------------------------------------------------------------------
`define SERN_GRP_OPER      1'h0
`define SERN_GRP_QUES      1'h1

// ----------------------------------------------------------------------
// Preset and reset values, and the answer of an empty error queue
// ----------------------------------------------------------------------
`define SERN_RISE_PRESET   16'hFFFF
`define SERN_FALL_PRESET   16'h0000
`define SERN_MASK_PRESET   16'h0000
`define SERN_NO_ERROR      16'h0000

// ----------------------------------------------------------------------
// Summary byte bit positions
// ----------------------------------------------------------------------
`define SERN_SB_ERRQ       2
`define SERN_SB_QUES       3
`define SERN_SB_OUTQ       4
`define SERN_SB_ESB        5
`define SERN_SB_OPER       7

`endif

// file: verif/sern_node_sva.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checks of the status node
// ----------------------------------------
module sern_node_sva (
	input logic        sys_clk_i,
	input logic        sys_rst_i,
	input logic [15:0] oper_cond_i,
	input logic        cmd_valid_i,
	input logic [2:0]  cmd_op_i,
	input logic        cmd_grp_i,
	input logic [1:0]  cmd_sel_i,
	input logic        rsp_valid_o,
	input logic [15:0] rsp_data_o,
	input logic        oper_sum_o,
	input logic        ques_sum_o,
	input logic [7:0]  summary_byte_o
);
	// Single domain, so clock and reset are given once
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// One answer per command, one cycle later
	chk_rsp_follow: assert property (cmd_valid_i |=> rsp_valid_o)
		else $error("no answer after command");
	chk_rsp_quiet: assert property (!cmd_valid_i |=> !rsp_valid_o)
		else $error("answer without command");
	chk_wr_zero: assert property (cmd_valid_i && cmd_op_i inside {[2:5]}
		|=> rsp_data_o == 16'h0000) else $error("write gave data");
	chk_preset_mask: assert property (cmd_valid_i && cmd_op_i == 3'h5 ##2
		cmd_valid_i && cmd_op_i == 3'h7 && !cmd_grp_i && cmd_sel_i == 2'h0
		|=> rsp_data_o == 16'h0000) else $error("mask kept after preset");
	chk_preset_sum: assert property (cmd_valid_i && cmd_op_i == 3'h5
		|-> ##2 !oper_sum_o && !ques_sum_o) else $error("sum after preset");
	chk_byte_spare: assert property (summary_byte_o[6] == 1'b0
		&& summary_byte_o[1:0] == 2'h0) else $error("spare byte bit set");
	// Synchroniser depth makes three quiet cycles enough
	chk_cond_read: assert property ($stable(oper_cond_i)[*3] ##0
		cmd_valid_i && cmd_op_i == 3'h0 && !cmd_grp_i
		|=> rsp_data_o == $past(oper_cond_i)) else $error("bad cond read");
	chk_event_clr: assert property ($stable(oper_cond_i)[*4] ##0
		cmd_valid_i && cmd_op_i == 3'h1 && !cmd_grp_i ##2
		cmd_valid_i && cmd_op_i == 3'h1 && !cmd_grp_i
		|=> rsp_data_o == 16'h0000) else $error("event not cleared");
endmodule // sern_node_sva

bind sern_node sern_node_sva sern_node_sva_inst (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .oper_cond_i(oper_cond_i),
	.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_grp_i(cmd_grp_i),
	.cmd_sel_i(cmd_sel_i), .rsp_valid_o(rsp_valid_o),
	.rsp_data_o(rsp_data_o), .oper_sum_o(oper_sum_o),
	.ques_sum_o(ques_sum_o), .summary_byte_o(summary_byte_o));

// file: verif/sern_ctl_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Remote controller issuing commands
// ----------------------------------------
module sern_ctl_model (
	input  logic        sys_clk_i,
	output logic        cmd_valid_o,
	output logic [2:0]  cmd_op_o,
	output logic        cmd_grp_o,
	output logic [1:0]  cmd_sel_o,
	output logic [15:0] cmd_wdata_o,
	input  logic        rsp_valid_i,
	input  logic [15:0] rsp_data_i
);
	// Idle from time zero
	initial {cmd_valid_o, cmd_op_o, cmd_grp_o, cmd_sel_o, cmd_wdata_o} = '0;
	// One command; lines scrambled after so stale data is never trusted
	task automatic xfer(input logic [2:0] op, input logic grp,
		input logic [1:0] sel, input logic [15:0] wd,
		output logic [15:0] rd, output logic ok);
		@(negedge sys_clk_i);
		{cmd_valid_o, cmd_op_o, cmd_grp_o, cmd_sel_o} = {1'b1, op, grp, sel};
		cmd_wdata_o = wd;
		@(negedge sys_clk_i);
		rd = rsp_data_i;
		ok = rsp_valid_i;
		cmd_valid_o = 1'b0;
		{cmd_op_o, cmd_grp_o, cmd_sel_o, cmd_wdata_o} = ~{op, grp, sel, wd};
	endtask
endmodule // sern_ctl_model

// file: verif/tb_status_event_register_node.sv
`timescale 1ns/100ps
module tb_status_event_register_node;
	logic        sys_clk_i = 1'b0, sys_rst_i = 1'b1, ok;
	logic [15:0] oper_cond_i = '0, ques_cond_i = '0, err_code_i = '0;
	logic        outq_sum_i = 1'b0, std_event_sum_i = 1'b0, err_push_i = 1'b0;
	logic        cmd_valid_i, cmd_grp_i, rsp_valid_o, oper_sum_o, ques_sum_o;
	logic [2:0]  cmd_op_i;
	logic [1:0]  cmd_sel_i;
	logic [15:0] cmd_wdata_i, rsp_data_o, rd, c1, e, v[2][3], q[$];
	logic [7:0]  summary_byte_o, esr;
	integer      num_errors = 0, n_tests = 0, seed = 32'hB7AF, cyc = 0, g, i;
	sern_node sern_node_inst (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.oper_cond_i(oper_cond_i), .ques_cond_i(ques_cond_i),
		.outq_sum_i(outq_sum_i), .std_event_sum_i(std_event_sum_i),
		.err_push_i(err_push_i), .err_code_i(err_code_i),
		.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_grp_i(cmd_grp_i),
		.cmd_sel_i(cmd_sel_i), .cmd_wdata_i(cmd_wdata_i),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
		.oper_sum_o(oper_sum_o), .ques_sum_o(ques_sum_o),
		.summary_byte_o(summary_byte_o));
	sern_ctl_model sern_ctl_model_inst (.sys_clk_i(sys_clk_i),
		.cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i), .cmd_grp_o(cmd_grp_i),
		.cmd_sel_o(cmd_sel_i), .cmd_wdata_o(cmd_wdata_i),
		.rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o));
	// Clock and hang guard
	always #10 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors = num_errors + 1;
			print_verdict;
		end
	end
	function logic [15:0] ev_exp(input logic [15:0] a, b, r, f);
		return (~a & b & r) | (a & ~b & f);
	endfunction
	task chk(input logic [15:0] got, exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cmd(input logic [2:0] op, input logic [1:0] sel, input logic [15:0] wd);
		sern_ctl_model_inst.xfer(op, g[0], sel, wd, rd, ok);
		chk({15'h0, ok}, 16'h0001);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		for (g = 0; g < 2; g++) begin
			// Stored parts hold every bit, all-ones corner on group 0
			for (i = 0; i < 3; i++) begin
				v[g][i] = (g == 0 && i == 2) ? 16'hFFFF : 16'($random(seed));
				cmd(3'h2 + i[2:0], 2'h0, v[g][i]);
			end
			for (i = 0; i < 3; i++) begin
				cmd(3'h7, i[1:0], 16'h0000);
				chk(rd, v[g][i]);
			end
			cmd(3'h1, 2'h0, 16'h0000);
			// Random condition steps, both edge directions
			for (i = 0; i < 3; i++) begin
				c1 = 16'($random(seed));
				e = ev_exp(g ? ques_cond_i : oper_cond_i, c1, v[g][2], v[g][1]);
				if (g) ques_cond_i = c1;
				else oper_cond_i = c1;
				repeat (6) @(negedge sys_clk_i);
				chk({15'h0, g ? ques_sum_o : oper_sum_o},
					{15'h0, |(e & v[g][0])});
				chk({15'h0, summary_byte_o[g ? 3 : 7]},
					{15'h0, |(e & v[g][0])});
				cmd(3'h0, 2'h0, 16'h0000);
				chk(rd, c1);
				cmd(3'h0, 2'h0, 16'h0000);
				chk(rd, c1);
				cmd(3'h1, 2'h0, 16'h0000);
				chk(rd, e);
				cmd(3'h1, 2'h0, 16'h0000);
				chk(rd, 16'h0000);
			end
		end
		$display("parts and edges test done");
		cmd(3'h5, 2'h0, 16'h0000);
		for (g = 0; g < 2; g++) begin
			cmd(3'h7, 2'h0, 16'h0000);
			chk(rd, 16'h0000);
			cmd(3'h7, 2'h1, 16'h0000);
			chk(rd, 16'h0000);
			cmd(3'h7, 2'h2, 16'h0000);
			chk(rd, 16'hFFFF);
			// Unused part select reads back as zero
			cmd(3'h7, 2'h3, 16'h0000);
			chk(rd, 16'h0000);
		end
		$display("preset test done");
		// Service setup: low 15 operation bits reported, bit 15 silent
		g = 0;
		oper_cond_i = 16'h0000;
		repeat (6) @(negedge sys_clk_i);
		cmd(3'h2, 2'h0, 16'h7FFF);
		cmd(3'h4, 2'h0, 16'h7FFF);
		cmd(3'h1, 2'h0, 16'h0000);
		oper_cond_i = 16'h8001;
		repeat (6) @(negedge sys_clk_i);
		chk({15'h0, summary_byte_o[7]}, 16'h0001);
		chk({8'h0, summary_byte_o & 8'hA8}, 16'h0080);
		cmd(3'h1, 2'h0, 16'h0000);
		chk(rd, 16'h0001);
		$display("service setup test done");
		// Error queue, negative code first, read back newest first
		cmd(3'h6, 2'h0, 16'h0000);
		chk(rd, 16'h0000);
		for (i = 0; i < 3; i++) begin
			@(negedge sys_clk_i);
			err_push_i = 1'b1;
			err_code_i = i ? 16'($random(seed)) : 16'hFFFF;
			q.push_back(err_code_i);
			// Standard event bits pass the error-only enable mask
			esr = 8'($random(seed));
			std_event_sum_i = |(esr & 8'h3C);
			outq_sum_i = 1'($random(seed));
			@(negedge sys_clk_i);
			err_push_i = 1'b0;
		end
		repeat (4) @(negedge sys_clk_i);
		chk({13'h0, summary_byte_o[5:4], summary_byte_o[2]},
			{13'h0, std_event_sum_i, outq_sum_i, 1'b1});
		chk({8'h0, summary_byte_o & 8'hA8},
			{10'h0, std_event_sum_i, 5'h0});
		for (i = 0; i < 3; i++) begin
			cmd(3'h6, 2'h0, 16'h0000);
			chk(rd, q.pop_back());
		end
		cmd(3'h6, 2'h0, 16'h0000);
		chk(rd, 16'h0000);
		repeat (2) @(negedge sys_clk_i);
		chk({15'h0, summary_byte_o[2]}, 16'h0000);
		$display("error queue test done");
		print_verdict;
	end
endmodule // tb_status_event_register_node
